//--- logic/bsse_pkg.sv
// Package of constants and types for the branch, skip and shift execution unit
// Functional notes
// - Skip the next instruction when the chosen register bit is zero; 1, 2 or 3 cycles.
// - Skip the next instruction when the chosen register bit is one; PC advances 2 or 3.
// - Skip the next instruction when the chosen I/O bit is zero; flags untouched.
// - Skip the next instruction when the chosen I/O bit is one; flags untouched.
// - Generic branch jumps to PC plus k plus 1 when flag bit s is one.
// - Generic branch jumps to PC plus k plus 1 when flag bit s is zero.
// - Equal branch needs zero flag one; unequal branch needs zero flag zero.
// - Carry one and unsigned lower branch on carry one; others on carry zero.
// - Negative branch needs N one; positive branch needs N zero.
// - Signed greater-or-equal needs N xor V zero; signed less needs it one.
// - Half-carry branches follow H being one or zero.
// - User bit branches follow T being one or zero.
// - Overflow branches follow V being one or zero.
// - Interrupt branches follow the global interrupt enable being one or zero.
// - Flag branches finish in 1 or 2 cycles and change no flag.
// - Shift left fills bit 0 with zero; updates Z, C, N, V, H.
// - Shift right fills bit 7 with zero; updates Z, C, N, V.
// - Rotate left takes old carry into bit 0, bit 7 into carry.
// - Rotate right takes old carry into bit 7, bit 0 into carry.
// - Signed shift right keeps bit 7; updates Z, C, N, V in one cycle.
package bsse_pkg;

  // Status flag word bit positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;

  // Reset values of the registered outputs
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST  = 8'h00;

  // Cycle counts of the single-cycle and multi-cycle cases
  localparam logic [1:0] CYC_ONE       = 2'h1;
  localparam logic [1:0] CYC_BRANCH    = 2'h2;
  localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
  localparam logic [1:0] CYC_SKIP_LONG = 2'h3;

  // Program counter steps for sequential flow and skips
  localparam int unsigned STEP_SEQ       = 1;
  localparam int unsigned STEP_SKIP_SHORT = 2;
  localparam int unsigned STEP_SKIP_LONG = 3;

  typedef enum logic [5:0] {
    compare_with_borrow_op   = 6'h00,
    compare_immediate_op     = 6'h01,
    skip_reg_bit_zero_op     = 6'h02,
    skip_reg_bit_one_op      = 6'h03,
    skip_io_bit_zero_op      = 6'h04,
    skip_io_bit_one_op       = 6'h05,
    branch_flag_one_op       = 6'h06,
    branch_flag_zero_op      = 6'h07,
    branch_equal_op          = 6'h08,
    branch_unequal_op        = 6'h09,
    branch_carry_one_op      = 6'h0a,
    branch_carry_zero_op     = 6'h0b,
    branch_unsigned_ge_op    = 6'h0c,
    branch_unsigned_lt_op    = 6'h0d,
    branch_negative_op       = 6'h0e,
    branch_positive_op       = 6'h0f,
    branch_signed_ge_op      = 6'h10,
    branch_signed_less_op    = 6'h11,
    branch_halfcarry_one_op  = 6'h12,
    branch_halfcarry_zero_op = 6'h13,
    branch_userbit_one_op    = 6'h14,
    branch_userbit_zero_op   = 6'h15,
    branch_overflow_one_op   = 6'h16,
    branch_overflow_zero_op  = 6'h17,
    branch_irq_on_op         = 6'h18,
    branch_irq_off_op        = 6'h19,
    shift_left_op            = 6'h1a,
    shift_right_op           = 6'h1b,
    rotate_left_op           = 6'h1c,
    rotate_right_op          = 6'h1d,
    signed_shift_right_op    = 6'h1e,
    nibble_swap_op           = 6'h1f,
    flag_force_one_op        = 6'h20,
    flag_force_zero_op       = 6'h21
  } bsse_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } bsse_state_t;

endpackage : bsse_pkg

//--- logic/bsse_exec.sv
// Execution unit for compares, skips, flag branches, shifts, swap and flag force
`timescale 1ns/1ps
`default_nettype none
module bsse_exec
  import bsse_pkg::*;
#(
  parameter int unsigned PC_W = 16
) (
  input  wire logic            ref_clk_in,      // Core clock, 40 MHz
  input  wire logic            nrst_in,         // Async reset, active low
  input  wire logic            start_in,        // Issue pulse, taken when ready
  input  wire bsse_op_t        op_in,           // Operation select
  input  wire logic [7:0]      rd_in,           // Destination register value
  input  wire logic [7:0]      rr_in,           // Source register or constant K
  input  wire logic [2:0]      bit_sel_in,      // Bit index b or flag index s
  input  wire logic [6:0]      offset_in,       // Signed branch offset k
  input  wire logic [PC_W-1:0] pc_in,           // Address of this instruction
  input  wire logic            io_bit_in,       // Value of I/O bit (A,b)
  input  wire logic            next_long_in,    // Following instruction is two words
  input  wire logic [7:0]      status_flags_word_in, // Current status flags
  output logic                 ready_out,       // Can take a new operation
  output logic                 done_out,        // Last cycle of the operation
  output logic [7:0]           result_out,      // Value for Rd
  output logic                 rd_write_out,    // Rd should take result_out
  output logic [7:0]           status_flags_word_out, // New status flags
  output logic [PC_W-1:0]      pc_next_out      // Next program counter
);

  // Subtract flags; chain keeps Z only if the old Z was set
  function automatic logic [7:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic chain,
                                           input logic [7:0] f);
    logic [7:0] r;
    logic [7:0] nf;
    r  = a - b - {7'h00, cin};
    nf = f;
    nf[FLG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    nf[FLG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    nf[FLG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    nf[FLG_N] = r[7];
    nf[FLG_S] = nf[FLG_N] ^ nf[FLG_V];
    nf[FLG_Z] = (r == 8'h00) & (~chain | f[FLG_Z]);
    return nf;
  endfunction : sub_flags

  // Shift flags; S is left alone, H only where the operation updates it
  function automatic logic [7:0] shift_flags(input logic [7:0] r, input logic c,
                                             input logic upd_h, input logic h,
                                             input logic [7:0] f);
    logic [7:0] nf;
    nf = f;
    nf[FLG_Z] = (r == 8'h00);
    nf[FLG_C] = c;
    nf[FLG_N] = r[7];
    nf[FLG_V] = r[7] ^ c;
    if (upd_h) begin
      nf[FLG_H] = h;
    end
    return nf;
  endfunction : shift_flags

  // Branch condition from the operation and the flags
  function automatic logic branch_taken(input bsse_op_t op, input logic [2:0] s,
                                        input logic [7:0] f);
    logic r;
    r = 1'b0;
    unique case (op)
      branch_flag_one_op:       r = f[s];
      branch_flag_zero_op:      r = ~f[s];
      branch_equal_op:          r = f[FLG_Z];
      branch_unequal_op:        r = ~f[FLG_Z];
      branch_carry_one_op,
      branch_unsigned_lt_op:    r = f[FLG_C];
      branch_carry_zero_op,
      branch_unsigned_ge_op:    r = ~f[FLG_C];
      branch_negative_op:       r = f[FLG_N];
      branch_positive_op:       r = ~f[FLG_N];
      branch_signed_ge_op:      r = ~(f[FLG_N] ^ f[FLG_V]);
      branch_signed_less_op:    r = f[FLG_N] ^ f[FLG_V];
      branch_halfcarry_one_op:  r = f[FLG_H];
      branch_halfcarry_zero_op: r = ~f[FLG_H];
      branch_userbit_one_op:    r = f[FLG_T];
      branch_userbit_zero_op:   r = ~f[FLG_T];
      branch_overflow_one_op:   r = f[FLG_V];
      branch_overflow_zero_op:  r = ~f[FLG_V];
      branch_irq_on_op:         r = f[FLG_I];
      branch_irq_off_op:        r = ~f[FLG_I];
      default:                  r = 1'b0;
    endcase
    return r;
  endfunction : branch_taken

  bsse_state_t     state_q;
  logic [1:0]      wait_q;
  logic [1:0]      cycles_d;
  logic            take;
  logic            is_branch;
  logic            is_skip;
  logic            skip_hit;
  logic [PC_W-1:0] offset_ext;
  logic [PC_W-1:0] pc_d;
  logic [7:0]      result_d;
  logic            rd_write_d;
  logic [7:0]      flags_d;
  logic [7:0]      fin;

  assign fin        = status_flags_word_in;
  assign take       = start_in & ready_out;
  assign offset_ext = {{(PC_W-7){offset_in[6]}}, offset_in};
  assign is_branch  = (op_in >= branch_flag_one_op) && (op_in <= branch_irq_off_op);
  assign is_skip    = (op_in >= skip_reg_bit_zero_op) && (op_in <= skip_io_bit_one_op);

  // Skip decision on register or I/O bit
  always_comb begin
    unique case (op_in)
      skip_reg_bit_zero_op: skip_hit = ~rr_in[bit_sel_in];
      skip_reg_bit_one_op:  skip_hit = rr_in[bit_sel_in];
      skip_io_bit_zero_op:  skip_hit = ~io_bit_in;
      skip_io_bit_one_op:   skip_hit = io_bit_in;
      default:              skip_hit = 1'b0;
    endcase
  end

  // Next PC and cycle count; flow ops never touch the flags
  always_comb begin
    pc_d     = pc_in + PC_W'(STEP_SEQ);
    cycles_d = CYC_ONE;
    if (is_skip && skip_hit) begin
      pc_d     = pc_in + (next_long_in ? PC_W'(STEP_SKIP_LONG) : PC_W'(STEP_SKIP_SHORT));
      cycles_d = next_long_in ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
    end else if (is_branch && branch_taken(op_in, bit_sel_in, fin)) begin
      pc_d     = pc_in + offset_ext + PC_W'(STEP_SEQ);
      cycles_d = CYC_BRANCH;
    end
  end

  // Data path for shifts, compares, swap and flag force
  always_comb begin
    result_d   = rd_in;
    rd_write_d = 1'b0;
    flags_d    = fin;
    unique case (op_in)
      compare_with_borrow_op: flags_d = sub_flags(rd_in, rr_in, fin[FLG_C], 1'b1, fin);
      compare_immediate_op:   flags_d = sub_flags(rd_in, rr_in, 1'b0, 1'b0, fin);
      shift_left_op: begin
        result_d   = {rd_in[6:0], 1'b0};
        rd_write_d = 1'b1;
        flags_d    = shift_flags(result_d, rd_in[7], 1'b1, rd_in[3], fin);
      end
      shift_right_op: begin
        result_d   = {1'b0, rd_in[7:1]};
        rd_write_d = 1'b1;
        flags_d    = shift_flags(result_d, rd_in[0], 1'b0, 1'b0, fin);
      end
      rotate_left_op: begin
        result_d   = {rd_in[6:0], fin[FLG_C]};
        rd_write_d = 1'b1;
        flags_d    = shift_flags(result_d, rd_in[7], 1'b1, rd_in[3], fin);
      end
      rotate_right_op: begin
        result_d   = {fin[FLG_C], rd_in[7:1]};
        rd_write_d = 1'b1;
        flags_d    = shift_flags(result_d, rd_in[0], 1'b0, 1'b0, fin);
      end
      signed_shift_right_op: begin
        result_d   = {rd_in[7], rd_in[7:1]};
        rd_write_d = 1'b1;
        flags_d    = shift_flags(result_d, rd_in[0], 1'b0, 1'b0, fin);
      end
      nibble_swap_op: begin
        result_d   = {rd_in[3:0], rd_in[7:4]};
        rd_write_d = 1'b1;
      end
      flag_force_one_op:  flags_d[bit_sel_in] = 1'b1;
      flag_force_zero_op: flags_d[bit_sel_in] = 1'b0;
      default: flags_d = fin;
    endcase
  end

  // Sequencer; a new op is only taken once the last one has finished
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      wait_q  <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_EXEC;
            wait_q  <= cycles_d - 2'h1;
          end
        end
        ST_EXEC: begin
          if (wait_q == 2'h0) begin
            state_q <= ST_IDLE;
          end else begin
            wait_q <= wait_q - 2'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          wait_q  <= 2'h0;
        end
      endcase
    end
  end

  // Results are latched at issue and held until the next issue
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_out            <= RESULT_RST;
      rd_write_out          <= 1'b0;
      status_flags_word_out <= FLAGS_RST;
      pc_next_out           <= '0;
    end else if (take) begin
      result_out            <= result_d;
      rd_write_out          <= rd_write_d;
      status_flags_word_out <= flags_d;
      pc_next_out           <= pc_d;
    end
  end

  // Handshake is combinational from state_q and wait_q; issue can come in the cycle after done, not in it
  assign ready_out = (state_q == ST_IDLE);
  assign done_out  = (state_q == ST_EXEC) && (wait_q == 2'h0);

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_skip_reg_zero: assert property (
    take && op_in == skip_reg_bit_zero_op && !rr_in[bit_sel_in] && !next_long_in
    |-> ##1 !done_out ##1 done_out && pc_next_out == $past(pc_in, 2) + PC_W'(STEP_SKIP_SHORT))
    else $error("register bit zero skip wrong");
  chk_skip_reg_one: assert property (
    take && op_in == skip_reg_bit_one_op && rr_in[bit_sel_in] && next_long_in
    |=> pc_next_out == $past(pc_in) + PC_W'(STEP_SKIP_LONG) && status_flags_word_out == $past(fin))
    else $error("register bit one skip wrong");
  chk_skip_io_long: assert property (
    take && op_in == skip_io_bit_one_op && io_bit_in && next_long_in
    |-> ##1 !done_out [*2] ##1 done_out)
    else $error("I/O skip over long instruction not three cycles");
  chk_skip_io_miss: assert property (
    take && op_in == skip_io_bit_zero_op && io_bit_in
    |=> done_out && pc_next_out == $past(pc_in) + PC_W'(STEP_SEQ))
    else $error("I/O skip not taken still skipped");
  chk_branch_target: assert property (
    take && op_in == branch_equal_op && fin[FLG_Z]
    |=> !done_out ##1 done_out && pc_next_out == $past(pc_in, 2) + $past(offset_ext, 2) + PC_W'(STEP_SEQ))
    else $error("equal branch target wrong");
  chk_branch_signed: assert property (
    take && op_in == branch_signed_less_op && (fin[FLG_N] == fin[FLG_V])
    |=> done_out && pc_next_out == $past(pc_in) + PC_W'(STEP_SEQ))
    else $error("signed less branch taken wrongly");
  chk_branch_flags: assert property (
    take && is_branch |=> status_flags_word_out == $past(fin) && !rd_write_out)
    else $error("branch altered flags");
  chk_shift_left: assert property (
    take && op_in == shift_left_op
    |=> result_out == {$past(rd_in[6:0]), 1'b0} && status_flags_word_out[FLG_C] == $past(rd_in[7])
        && status_flags_word_out[FLG_H] == $past(rd_in[3]) && done_out)
    else $error("shift left wrong");
  chk_rotate_right: assert property (
    take && op_in == rotate_right_op
    |=> result_out[7] == $past(fin[FLG_C]) && status_flags_word_out[FLG_C] == $past(rd_in[0]))
    else $error("rotate right carry wrong");
  chk_signed_shift: assert property (
    take && op_in == signed_shift_right_op |=> result_out[7:6] == {2{$past(rd_in[7])}})
    else $error("signed shift lost sign");
  chk_compare_nowrite: assert property (
    take && op_in == compare_immediate_op
    |=> !rd_write_out && status_flags_word_out[FLG_Z] == ($past(rd_in) == $past(rr_in)))
    else $error("compare wrote Rd or bad zero");
  chk_flag_force: assert property (
    take && op_in == flag_force_zero_op |=> status_flags_word_out[$past(bit_sel_in)] == 1'b0)
    else $error("flag clear failed");
  chk_branch_generic: assert property (
    take && op_in == branch_flag_one_op && !fin[bit_sel_in]
    |=> done_out && pc_next_out == $past(pc_in) + PC_W'(STEP_SEQ))
    else $error("generic branch taken on clear flag");
  chk_branch_clear: assert property (
    take && op_in == branch_flag_zero_op && !fin[bit_sel_in]
    |=> !done_out ##1 done_out && pc_next_out == $past(pc_in, 2) + $past(offset_ext, 2) + PC_W'(STEP_SEQ))
    else $error("generic clear branch target wrong");
  chk_branch_carry: assert property (
    take && (op_in == branch_unsigned_ge_op || op_in == branch_carry_zero_op) && fin[FLG_C]
    |=> done_out && pc_next_out == $past(pc_in) + PC_W'(STEP_SEQ))
    else $error("carry clear branch taken on carry");
  chk_branch_irq: assert property (
    take && op_in == branch_irq_off_op && !fin[FLG_I]
    |=> !done_out ##1 done_out && pc_next_out == $past(pc_in, 2) + $past(offset_ext, 2) + PC_W'(STEP_SEQ))
    else $error("interrupt off branch target wrong");
  chk_shift_right: assert property (
    take && op_in == shift_right_op
    |=> result_out == {1'b0, $past(rd_in[7:1])} && status_flags_word_out[FLG_C] == $past(rd_in[0])
        && status_flags_word_out[FLG_H] == $past(fin[FLG_H]))
    else $error("shift right wrong");
  chk_rotate_left: assert property (
    take && op_in == rotate_left_op
    |=> result_out == {$past(rd_in[6:0]), $past(fin[FLG_C])}
        && status_flags_word_out[FLG_C] == $past(rd_in[7]))
    else $error("rotate left wrong");
  chk_nibble_swap: assert property (
    take && op_in == nibble_swap_op
    |=> result_out == {$past(rd_in[3:0]), $past(rd_in[7:4])}
        && status_flags_word_out == $past(fin) && rd_write_out)
    else $error("nibble swap wrong");

endmodule : bsse_exec
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the branch, skip and shift execution unit
`timescale 1ns/1ps
`default_nettype none
module tb
  import bsse_pkg::*;
;
  localparam int DRV = 1;
  logic            ref_clk_in = 1'b0;
  logic            nrst_in = 1'b0;
  logic            start_in = 1'b0;
  bsse_op_t        op_in = compare_with_borrow_op;
  logic [7:0]      rd_in = 8'h00, rr_in = 8'h00, status_flags_word_in = 8'h00;
  logic [2:0]      bit_sel_in = 3'h0;
  logic [6:0]      offset_in = 7'h00;
  logic [15:0]     pc_in = 16'h0000;
  logic            io_bit_in = 1'b0, next_long_in = 1'b0;
  logic            ready_out, done_out, rd_write_out;
  logic [7:0]      result_out, status_flags_word_out;
  logic [15:0]     pc_next_out;
  int              num_errors = 0, n_compared = 0, cyc;

  bsse_exec #(.PC_W(16)) dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .start_in(start_in), .op_in(op_in),
    .rd_in(rd_in), .rr_in(rr_in), .bit_sel_in(bit_sel_in), .offset_in(offset_in), .pc_in(pc_in),
    .io_bit_in(io_bit_in), .next_long_in(next_long_in), .status_flags_word_in(status_flags_word_in),
    .ready_out(ready_out), .done_out(done_out), .result_out(result_out), .rd_write_out(rd_write_out),
    .status_flags_word_out(status_flags_word_out), .pc_next_out(pc_next_out));

  // 40 MHz core clock
  always #12.5 ref_clk_in = ~ref_clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // Issue one op, count cycles to done, return just after the done cycle ends
  task automatic run_op(input bsse_op_t op, input logic [7:0] rd, input logic [7:0] rr, input logic [2:0] bs,
                        input logic [6:0] k, input logic io, input logic lng, input logic [7:0] fl);
    op_in = op; rd_in = rd; rr_in = rr; bit_sel_in = bs; offset_in = k;
    io_bit_in = io; next_long_in = lng; status_flags_word_in = fl; pc_in = 16'h0010;
    start_in = 1'b1;
    @(posedge ref_clk_in); #DRV;
    start_in = 1'b0;
    cyc = 1;
    // Bounded wait so a missing done pulse cannot hang the run
    while (done_out !== 1'b1 && cyc < 8) begin
      @(posedge ref_clk_in); #DRV;
      cyc++;
    end
    @(posedge ref_clk_in); #DRV;
    check(ready_out, 1'b1);
  endtask : run_op

  // Own reference for which flag branches are taken
  function automatic logic br_take(input bsse_op_t op, input logic [7:0] f, input logic [2:0] s);
    case (op)
      branch_flag_one_op:       return f[s];
      branch_flag_zero_op:      return !f[s];
      branch_equal_op:          return f[FLG_Z];
      branch_unequal_op:        return !f[FLG_Z];
      branch_carry_one_op, branch_unsigned_lt_op:  return f[FLG_C];
      branch_carry_zero_op, branch_unsigned_ge_op: return !f[FLG_C];
      branch_negative_op:       return f[FLG_N];
      branch_positive_op:       return !f[FLG_N];
      branch_signed_ge_op:      return !(f[FLG_N] ^ f[FLG_V]);
      branch_signed_less_op:    return f[FLG_N] ^ f[FLG_V];
      branch_halfcarry_one_op:  return f[FLG_H];
      branch_halfcarry_zero_op: return !f[FLG_H];
      branch_userbit_one_op:    return f[FLG_T];
      branch_userbit_zero_op:   return !f[FLG_T];
      branch_overflow_one_op:   return f[FLG_V];
      branch_irq_on_op:         return f[FLG_I];
      default:                  return op == branch_overflow_zero_op ? !f[FLG_V] : !f[FLG_I];
    endcase
  endfunction : br_take

  task automatic test_reset();
    check({ready_out, done_out, rd_write_out}, 3'h4);
    check({result_out, status_flags_word_out, pc_next_out}, 32'h0);
  endtask : test_reset

  // Every flag branch against a spread of flag words, both offset signs
  task automatic test_branches();
    logic [7:0] pat [6] = '{8'h00, 8'hff, 8'h04, 8'h08, 8'h55, 8'haa};
    logic [6:0] k;
    logic       tk;
    for (int i = 6; i <= 25; i++) begin
      for (int j = 0; j < 6; j++) begin
        k = j[0] ? 7'h40 : 7'h3f;
        tk = br_take(bsse_op_t'(i), pat[j], 3'(j + i));
        run_op(bsse_op_t'(i), 8'h00, 8'h00, 3'(j + i), k, 1'b0, 1'b0, pat[j]);
        check(pc_next_out, tk ? 16'h0011 + {{9{k[6]}}, k} : 16'h0011);
        check(cyc, tk ? 2 : 1);
        check(status_flags_word_out, pat[j]);
      end
    end
  endtask : test_branches

  // Skips on register and I/O bits, taken short, taken long and not taken
  task automatic test_skips();
    logic       tk;
    logic [7:0] m;
    for (int i = 2; i <= 5; i++) begin
      for (int v = 0; v < 4; v++) begin
        tk = (v[0] == i[0]);
        m = 8'h20;
        // The unused source carries the opposite value to catch a mixed-up input
        if ((i < 4) ? !v[0] : v[0]) m = ~m;
        run_op(bsse_op_t'(i), 8'h00, m, 3'h5, 7'h00, (i < 4) ? !v[0] : v[0], v[1], 8'h5a);
        check(pc_next_out, tk ? (v[1] ? 16'h0013 : 16'h0012) : 16'h0011);
        check(cyc, tk ? (v[1] ? 3 : 2) : 1);
        check({rd_write_out, status_flags_word_out}, {1'b0, 8'h5a});
      end
    end
  endtask : test_skips

  // Shifts and rotates, old carry both ways
  task automatic test_shifts();
    logic [7:0] vals [4] = '{8'h81, 8'h08, 8'h00, 8'h7f};
    logic [7:0] r, ef, fl;
    logic       c;
    for (int i = 26; i <= 30; i++) begin
      for (int j = 0; j < 8; j++) begin
        fl = {8'h50 | 8'(j[2])};
        case (bsse_op_t'(i))
          shift_left_op:   {c, r} = {vals[j%4], 1'b0};
          shift_right_op:  {r, c} = {1'b0, vals[j%4]};
          rotate_left_op:  {c, r} = {vals[j%4], fl[FLG_C]};
          rotate_right_op: {r, c} = {fl[FLG_C], vals[j%4]};
          default:         {r, c} = {vals[j%4][7], vals[j%4]};
        endcase
        ef = fl;
        ef[FLG_C] = c;
        ef[FLG_Z] = (r == 8'h00);
        ef[FLG_N] = r[7];
        ef[FLG_V] = r[7] ^ c;
        if (i == 26 || i == 28) ef[FLG_H] = vals[j%4][3];
        run_op(bsse_op_t'(i), vals[j%4], 8'h00, 3'h0, 7'h00, 1'b0, 1'b0, fl);
        check({rd_write_out, result_out}, {1'b1, r});
        check(status_flags_word_out, ef);
        check(cyc, 1);
      end
    end
  endtask : test_shifts

  // Compare with carry and with constant; Rd is never written
  task automatic test_compares();
    logic [7:0] a [4] = '{8'h00, 8'h80, 8'h10, 8'h05};
    logic [7:0] b [4] = '{8'h01, 8'h01, 8'h01, 8'h05};
    logic [7:0] fl [3] = '{8'h02, 8'h01, 8'h03};
    logic [8:0] d;
    logic [4:0] hd;
    logic [7:0] ef;
    logic       cin;
    for (int op = 0; op < 2; op++) begin
      for (int j = 0; j < 12; j++) begin
        cin = (op == 0) ? fl[j/4][FLG_C] : 1'b0;
        d = {1'b0, a[j%4]} - {1'b0, b[j%4]} - 9'(cin);
        hd = {1'b0, a[j%4][3:0]} - {1'b0, b[j%4][3:0]} - 5'(cin);
        ef = fl[j/4];
        ef[FLG_C] = d[8];
        ef[FLG_Z] = (d[7:0] == 8'h00) && (op == 1 || fl[j/4][FLG_Z]);
        ef[FLG_N] = d[7];
        ef[FLG_V] = (a[j%4][7] & ~b[j%4][7] & ~d[7]) | (~a[j%4][7] & b[j%4][7] & d[7]);
        ef[FLG_S] = ef[FLG_N] ^ ef[FLG_V];
        ef[FLG_H] = hd[4];
        run_op(bsse_op_t'(op), a[j%4], b[j%4], 3'h0, 7'h00, 1'b0, 1'b0, fl[j/4]);
        check(status_flags_word_out, ef);
        check(rd_write_out, 1'b0);
      end
    end
  endtask : test_compares

  // Nibble swap and forcing each flag bit
  task automatic test_swap_force();
    run_op(nibble_swap_op, 8'h3c, 8'h00, 3'h0, 7'h00, 1'b0, 1'b0, 8'h96);
    check({rd_write_out, result_out, status_flags_word_out}, {1'b1, 8'hc3, 8'h96});
    for (int s = 0; s < 8; s++) begin
      run_op(flag_force_one_op, 8'h00, 8'h00, 3'(s), 7'h00, 1'b0, 1'b0, 8'h00);
      check(status_flags_word_out, 8'(8'h01 << s));
      check(cyc, 1);
      run_op(flag_force_zero_op, 8'h00, 8'h00, 3'(s), 7'h00, 1'b0, 1'b0, 8'hff);
      check(status_flags_word_out, 8'(~(8'h01 << s)));
    end
  endtask : test_swap_force

  // A request during a taken branch must be ignored
  task automatic test_refused();
    op_in = branch_equal_op; offset_in = 7'h05; status_flags_word_in = 8'h02; pc_in = 16'h0100;
    start_in = 1'b1;
    @(posedge ref_clk_in); #DRV;
    op_in = shift_left_op; rd_in = 8'hff;
    check({ready_out, done_out}, 2'b00);
    @(posedge ref_clk_in); #DRV;
    start_in = 1'b0;
    check({done_out, pc_next_out, rd_write_out}, {1'b1, 16'h0106, 1'b0});
    @(posedge ref_clk_in); #DRV;
    check({ready_out, done_out}, 2'b10);
  endtask : test_refused

  // Watchdog sized well beyond the expected run
  initial begin
    #(25 * 20000);
    num_errors++;
    stop_test();
  end

  // Main sequence: reset for 10 cycles, then the scenarios
  initial begin
    repeat (10) @(posedge ref_clk_in);
    #DRV;
    test_reset();
    nrst_in = 1'b1;
    @(posedge ref_clk_in); #DRV;
    test_branches();
    test_skips();
    test_shifts();
    test_compares();
    test_swap_force();
    test_refused();
    stop_test();
  end
endmodule : tb
`default_nettype wire
